// *** core/pcmc_pkg.sv ***
package pcmc_pkg;

    // Register map, one aligned 32-bit word
    localparam logic [11:0] PCMC_ADDR_MODE_CTRL  = 12'h000;
    localparam logic [11:0] PCMC_ADDR_STATUS     = 12'h004;
    localparam logic [11:0] PCMC_ADDR_PWR_SAVE   = 12'h008;

    // Power mode control fields
    localparam int          PCMC_BIT_SLOW_ON     = 7;
    localparam int          PCMC_BIT_FAST_ON     = 6;
    localparam int          PCMC_BIT_DUAL_EN     = 5;
    localparam int          PCMC_BIT_CORE_SEL    = 4;
    localparam int          PCMC_BIT_RSVD        = 3;
    localparam int          PCMC_WIN_MSB         = 2;
    localparam logic [7:0]  PCMC_MODE_CTRL_RST   = 8'h40;

    // Legal upper-nibble patterns
    localparam logic [3:0]  PCMC_NIB_HIGH        = 4'h4;
    localparam logic [3:0]  PCMC_NIB_HS_DUAL     = 4'hc;
    localparam logic [3:0]  PCMC_NIB_DUAL        = 4'he;
    localparam logic [3:0]  PCMC_NIB_DUAL_LS     = 4'hf;
    localparam logic [3:0]  PCMC_NIB_LOW         = 4'hb;

    // Power save request field of the power save register
    localparam int          PCMC_BIT_IDLE_REQ    = 0;
    localparam int          PCMC_BIT_HALT_REQ    = 1;

    // Self reset pulse length in core cycles
    localparam int          PCMC_SELF_RST_CYCLES = 4;

    // Slow oscillator nominal frequency
    localparam int          PCMC_SLOW_OSC_HZ     = 32768;

    // Decoded operating modes, gray coded along high->dual->low
    typedef enum logic [1:0] {
        PCMC_MODE_HIGH = 2'b00,
        PCMC_MODE_DUAL = 2'b01,
        PCMC_MODE_LOW  = 2'b11
    } pcmc_mode_e;

    // Power save states
    typedef enum logic [1:0] {
        PCMC_PS_RUN  = 2'b00,
        PCMC_PS_IDLE = 2'b01,
        PCMC_PS_HALT = 2'b11
    } pcmc_ps_e;

endpackage : pcmc_pkg

// *** core/pcmc_top.sv ***
// Functional notes
// [R01] Reset loads mode control with 40h
// [R02] Bit 7 switches slow oscillator
// [R03] Bit 6 switches fast oscillator
// [R04] Bit 5 picks idle timer clock
// [R05] Software stabilises slow oscillator first
// [R06] Bit 4 picks core clock source
// [R07] Software stabilises target clock first
// [R08] Mode decoded from bits 5 and 4
// [R09] Select without enable forces low speed
// [R10] Software writes zero to bit 3
// [R11] Low three bits feed idle window
// [R12] Illegal upper nibble resets the device
// [R13] Software steps modes in fixed order
// [R14] Software configures slow oscillator pins
// [R15] Idle keeps oscillator, timer, monitor running
// [R16] Halt stops all; option enables it
// [R17] Power save freezes everything but idle timer
// [R18] Slow 32 kHz pins, fast main input
// [R19] High speed after reset, via dual
// [R20] Leave dual: clear enable, then slow
// [R21] Check each write; reset within cycles
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pcmc_top
    import pcmc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // APB slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // Option and wake-up
    input  wire logic        HALT_ENABLE_OPT_I,
    input  wire logic        WAKEUP_I,
    // Oscillator control
    output logic             SLOW_OSC_ON_O,
    output logic             FAST_OSC_ON_O,
    output logic             IDLE_TIMER_SLOW_CLK_O,
    output logic             CORE_SLOW_CLK_O,
    output logic [1:0]       MODE_O,
    output logic [2:0]       IDLE_WINDOW_SELECT_O,
    // Power save gating
    output logic             CORE_RUN_O,
    output logic             FREEZE_O,
    output logic             OSC_RUN_O,
    output logic             IDLE_TIMER_RUN_O,
    output logic             CLOCK_MONITOR_RUN_O,
    // Self reset request
    output logic             SELF_RESET_O
);

    logic [7:0]       mode_ctrl_reg;
    logic [7:0]       mode_ctrl_next;
    pcmc_mode_e       mode;
    pcmc_ps_e         ps_reg;
    pcmc_ps_e         ps_next;
    logic [2:0]       rst_cnt_reg;
    logic             self_rst_reg;
    logic             illegal;
    logic             wake_s1_reg;
    logic             wake_s2_reg;
    logic             opt_s1_reg;
    logic             opt_s2_reg;
    logic             wr_en;
    logic             rd_en;
    logic             addr_ok;
    logic [3:0]       nib;

    assign wr_en   = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd_en   = PSEL_I && PENABLE_I && !PWRITE_I;
    assign addr_ok = (PADDR_I == PCMC_ADDR_MODE_CTRL) || (PADDR_I == PCMC_ADDR_STATUS)
                     || (PADDR_I == PCMC_ADDR_PWR_SAVE);

    // Zero wait states; unmapped addresses answer with an error
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;

    // Only lane 0 carries the byte-wide register
    always_comb begin
        mode_ctrl_next = mode_ctrl_reg;
        if (wr_en && PADDR_I == PCMC_ADDR_MODE_CTRL && PSTRB_I[0]) begin
            mode_ctrl_next = PWDATA_I[7:0];
        end
    end

    // Self reset also reloads the register so the core regains a clock
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_ctrl_reg <= PCMC_MODE_CTRL_RST; // [R01] [R19]
        end else if (self_rst_reg) begin
            mode_ctrl_reg <= PCMC_MODE_CTRL_RST; // [R19]
        end else begin
            mode_ctrl_reg <= mode_ctrl_next;
        end
    end

    assign nib = mode_ctrl_reg[7:4];

    // Checked on the stored value, so the reset follows the write by one edge
    always_comb begin
        case (nib)
            PCMC_NIB_HIGH, PCMC_NIB_HS_DUAL, PCMC_NIB_DUAL,
            PCMC_NIB_DUAL_LS, PCMC_NIB_LOW: illegal = 1'b0;
            default:                        illegal = 1'b1; // [R12]
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rst_cnt_reg  <= 3'h0;
            self_rst_reg <= 1'b0;
        end else if (self_rst_reg) begin
            if (rst_cnt_reg == 3'(PCMC_SELF_RST_CYCLES - 1)) begin
                self_rst_reg <= 1'b0;
                rst_cnt_reg  <= 3'h0;
            end else begin
                rst_cnt_reg  <= rst_cnt_reg + 3'h1;
            end
        end else if (illegal) begin
            self_rst_reg <= 1'b1; // [R12] [R21]
        end
    end

    assign SELF_RESET_O = self_rst_reg;

    // Mode decode; select without enable falls to low speed
    always_comb begin
        case ({mode_ctrl_reg[PCMC_BIT_DUAL_EN], mode_ctrl_reg[PCMC_BIT_CORE_SEL]})
            2'b00:   mode = PCMC_MODE_HIGH; // [R08]
            2'b10:   mode = PCMC_MODE_DUAL; // [R08]
            2'b11:   mode = PCMC_MODE_LOW;  // [R08]
            2'b01:   mode = PCMC_MODE_LOW;  // [R09]
            default: mode = PCMC_MODE_HIGH;
        endcase
    end

    assign MODE_O = mode;

    // Slow source is the 32 kHz pin pair, fast source the main input
    assign SLOW_OSC_ON_O         = mode_ctrl_reg[PCMC_BIT_SLOW_ON]; // [R02] [R18]
    assign FAST_OSC_ON_O         = mode_ctrl_reg[PCMC_BIT_FAST_ON]; // [R03] [R18]
    assign IDLE_TIMER_SLOW_CLK_O = mode_ctrl_reg[PCMC_BIT_DUAL_EN]; // [R04]
    assign CORE_SLOW_CLK_O       = (mode == PCMC_MODE_LOW); // [R06] [R09]
    assign IDLE_WINDOW_SELECT_O  = mode_ctrl_reg[PCMC_WIN_MSB:0]; // [R11]

    // Wake-up comes from a pin
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wake_s1_reg <= 1'b0;
            wake_s2_reg <= 1'b0;
        end else begin
            wake_s1_reg <= WAKEUP_I;
            wake_s2_reg <= wake_s1_reg;
        end
    end

    // Option strap comes from a pin as well, so it is synchronised like wake-up
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            opt_s1_reg <= 1'b0;
            opt_s2_reg <= 1'b0;
        end else begin
            opt_s1_reg <= HALT_ENABLE_OPT_I;
            opt_s2_reg <= opt_s1_reg;
        end
    end

    // Power save entry; halt is ignored unless the option allows it
    always_comb begin
        ps_next = ps_reg;
        case (ps_reg)
            PCMC_PS_RUN: begin
                if (wr_en && PADDR_I == PCMC_ADDR_PWR_SAVE && PSTRB_I[0]) begin
                    if (PWDATA_I[PCMC_BIT_HALT_REQ] && opt_s2_reg) begin
                        ps_next = PCMC_PS_HALT; // [R16]
                    end else if (PWDATA_I[PCMC_BIT_IDLE_REQ]) begin
                        ps_next = PCMC_PS_IDLE; // [R15]
                    end
                end
            end
            PCMC_PS_IDLE: begin
                if (wake_s2_reg) begin
                    ps_next = PCMC_PS_RUN;
                end
            end
            PCMC_PS_HALT: begin
                if (wake_s2_reg) begin
                    ps_next = PCMC_PS_RUN;
                end
            end
            default: ps_next = PCMC_PS_RUN;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ps_reg <= PCMC_PS_RUN;
        end else if (self_rst_reg) begin
            ps_reg <= PCMC_PS_RUN;
        end else begin
            ps_reg <= ps_next;
        end
    end

    // Idle stops execution only; halt stops the oscillator and idle timer too
    assign CORE_RUN_O          = (ps_reg == PCMC_PS_RUN); // [R15] [R16]
    assign FREEZE_O            = (ps_reg != PCMC_PS_RUN); // [R17]
    assign OSC_RUN_O           = (ps_reg != PCMC_PS_HALT); // [R15] [R16]
    assign IDLE_TIMER_RUN_O    = (ps_reg != PCMC_PS_HALT); // [R15] [R17]
    assign CLOCK_MONITOR_RUN_O = (ps_reg != PCMC_PS_HALT); // [R15]

    // Read data is registered on the setup phase address
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PRDATA_O <= 32'h0;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            case (PADDR_I)
                PCMC_ADDR_MODE_CTRL: PRDATA_O <= {24'h0, mode_ctrl_reg};
                PCMC_ADDR_STATUS:    PRDATA_O <= {28'h0, self_rst_reg, illegal, mode};
                PCMC_ADDR_PWR_SAVE:  PRDATA_O <= {30'h0, ps_reg};
                default:             PRDATA_O <= 32'h0;
            endcase
        end
    end

endmodule : pcmc_top

`default_nettype wire

// *** bench/pcmc_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcmc_props
    import pcmc_pkg::*;
(
    // Clock, reset, bus
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0]  PSTRB_I,
    // Mode outputs
    input wire logic        SLOW_OSC_ON_O,
    input wire logic        FAST_OSC_ON_O,
    input wire logic        IDLE_TIMER_SLOW_CLK_O,
    input wire logic        CORE_SLOW_CLK_O,
    input wire logic [1:0]  MODE_O,
    input wire logic [2:0]  IDLE_WINDOW_SELECT_O,
    input wire logic        SELF_RESET_O
);
    logic [7:0] wd;
    wire logic  wr = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == PCMC_ADDR_MODE_CTRL && PSTRB_I[0];
    wire logic  bad = wr && !(PWDATA_I[7:4] inside {4'h4, 4'hc, 4'he, 4'hf, 4'hb});
    // Data seen at the write edge, compared one cycle later
    always_ff @(posedge CLK_I) wd <= PWDATA_I[7:0];
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    a_slow_osc_bit: assert property (wr |=> SLOW_OSC_ON_O == wd[7])
        else $error("slow oscillator enable wrong");
    a_fast_osc_bit: assert property (wr |=> FAST_OSC_ON_O == wd[6])
        else $error("fast oscillator enable wrong");
    a_idle_clk_bit: assert property (wr |=> IDLE_TIMER_SLOW_CLK_O == wd[5])
        else $error("idle timer clock wrong");
    a_core_clk_sel: assert property (wr |=> CORE_SLOW_CLK_O == wd[4])
        else $error("core clock select wrong");
    a_window_bits: assert property (wr |=> IDLE_WINDOW_SELECT_O == wd[2:0])
        else $error("idle window wrong");
    a_mode_decode: assert property (wr |=> MODE_O == {wd[4], wd[5] | wd[4]})
        else $error("mode decode wrong");
    a_illegal_reset: assert property (bad |-> ##[1:3] SELF_RESET_O)
        else $error("no self reset on illegal value");
    a_self_rst_len: assert property ($rose(SELF_RESET_O) |-> SELF_RESET_O [*4] ##1 !SELF_RESET_O)
        else $error("self reset length wrong");
    a_reload_after: assert property ($rose(SELF_RESET_O) |-> ##[0:2] (FAST_OSC_ON_O && !SLOW_OSC_ON_O
        && MODE_O == 2'b00))
        else $error("no reload after self reset");
    a_reset_value: assert property ($fell(RST_I) |-> FAST_OSC_ON_O && !SLOW_OSC_ON_O
        && MODE_O == 2'b00 && IDLE_WINDOW_SELECT_O == 3'h0)
        else $error("reset value wrong");
endmodule : pcmc_props
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pcmc_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, hopt = 0, wake = 0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rdv;
    logic [3:0]  pstb = 4'h1;
    logic        prdy, perr, lerr, slow, fast, itclk, cslow, crun, frz, orun, itrun, cmrun, srst;
    logic [1:0]  mode;
    logic [2:0]  win;
    logic [7:0]  v;
    logic [7:0]  seq [9] = '{8'h40, 8'hc5, 8'he7, 8'hf2, 8'hb3, 8'hf6, 8'he1, 8'hc4, 8'h40};
    int          num_errors = 0, checks = 0;
    pcmc_top dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(padr), .PWDATA_I(pwd), .PSTRB_I(pstb), .PRDATA_O(prd), .PREADY_O(prdy),
        .PSLVERR_O(perr), .HALT_ENABLE_OPT_I(hopt), .WAKEUP_I(wake), .SLOW_OSC_ON_O(slow),
        .FAST_OSC_ON_O(fast), .IDLE_TIMER_SLOW_CLK_O(itclk), .CORE_SLOW_CLK_O(cslow),
        .MODE_O(mode), .IDLE_WINDOW_SELECT_O(win), .CORE_RUN_O(crun), .FREEZE_O(frz),
        .OSC_RUN_O(orun), .IDLE_TIMER_RUN_O(itrun), .CLOCK_MONITOR_RUN_O(cmrun),
        .SELF_RESET_O(srst));
    initial forever #5 clk = ~clk;
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; padr <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        do begin @(posedge clk); n++; end while (prdy !== 1'b1 && n < 20);
        rdv = prd;
        lerr = perr;
        psel <= 0; pen <= 0;
        if (n >= 20) begin num_errors++; tally_and_finish; end
    endtask : apb
    // Bounded wait on core run (s=1) or self reset (s=0)
    task automatic wt(input logic s, input logic val);
        repeat (12) if ((s ? crun : srst) !== val) @(posedge clk);
        if ((s ? crun : srst) !== val) begin num_errors++; tally_and_finish; end
    endtask : wt
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        apb(0, PCMC_ADDR_MODE_CTRL, 32'h0); chk(rdv, 32'h40);
        chk(lerr, 1'b0);
        chk({fast, slow, mode, win, srst}, 8'h80);
        foreach (seq[i]) begin
            v = seq[i];
            apb(1, PCMC_ADDR_MODE_CTRL, {24'h0, v});
            apb(0, PCMC_ADDR_MODE_CTRL, 32'h0); chk(rdv, {24'h0, v});
            @(negedge clk);
            chk({slow, fast, itclk, cslow, mode, win, srst}, {v[7:4], v[4], v[5] | v[4], v[2:0], 1'b0});
            apb(0, PCMC_ADDR_STATUS, 32'h0); chk(rdv, {28'h0, 2'b00, v[4], v[5] | v[4]});
        end
        pstb <= 4'h0;
        apb(1, PCMC_ADDR_MODE_CTRL, 32'hc0);
        pstb <= 4'h1;
        apb(0, PCMC_ADDR_MODE_CTRL, 32'h0); chk(rdv, 32'h40);
        apb(0, 12'h010, 32'h0); chk(rdv, 32'h0); chk(lerr, 1'b1);
        for (int n = 0; n < 16; n++) if (!(n[3:0] inside {4'h4, 4'hc, 4'he, 4'hf, 4'hb})) begin
            v = {n[3:0], 4'h0};
            apb(1, PCMC_ADDR_MODE_CTRL, {24'h0, v});
            @(negedge clk); chk(mode, {v[4], v[5] | v[4]});
            wt(0, 1); wt(0, 0);
            apb(0, PCMC_ADDR_MODE_CTRL, 32'h0); chk(rdv, 32'h40);
        end
        apb(1, PCMC_ADDR_MODE_CTRL, 32'hc5);
        apb(1, PCMC_ADDR_PWR_SAVE, 32'h2); @(negedge clk); chk(crun, 1'b1);
        apb(1, PCMC_ADDR_PWR_SAVE, 32'h1); @(negedge clk); chk({crun, frz, orun, itrun, cmrun}, 5'h0f);
        wake <= 1; wt(1, 1); wake <= 0;
        // Let the wake and option synchronisers settle before the next request
        hopt <= 1;
        repeat (3) @(posedge clk);
        apb(1, PCMC_ADDR_PWR_SAVE, 32'h2); @(negedge clk); chk({crun, frz, orun, itrun, cmrun}, 5'h08);
        wake <= 1; wt(1, 1); wake <= 0;
        apb(0, PCMC_ADDR_MODE_CTRL, 32'h0); chk(rdv, 32'hc5);
        tally_and_finish;
    end
endmodule : testbench
bind pcmc_top pcmc_props u_props (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PSTRB_I(PSTRB_I), .SLOW_OSC_ON_O(SLOW_OSC_ON_O), .FAST_OSC_ON_O(FAST_OSC_ON_O),
    .IDLE_TIMER_SLOW_CLK_O(IDLE_TIMER_SLOW_CLK_O), .CORE_SLOW_CLK_O(CORE_SLOW_CLK_O),
    .MODE_O(MODE_O), .IDLE_WINDOW_SELECT_O(IDLE_WINDOW_SELECT_O), .SELF_RESET_O(SELF_RESET_O));
`default_nettype wire
